// ===== fet_cfg.svh
// Constants for the fast Ethernet transmit code-group encoder
`ifndef FET_CFG_SVH
`define FET_CFG_SVH

// Code-group width and last bit index within a group
`define FET_CG_W          5
`define FET_CG_LAST       3'h4

// Control code-groups
`define FET_CG_IDLE       5'h1f
`define FET_CG_J          5'h18
`define FET_CG_K          5'h11
`define FET_CG_T          5'h0d
`define FET_CG_R          5'h07
`define FET_CG_HALT       5'h04

// Scrambler length, feedback taps and seed fill bits
`define FET_LFSR_W        11
`define FET_LFSR_TAP_HI   10
`define FET_LFSR_TAP_LO   8
`define FET_SEED_FILL     6'h3f

// Cycles after reset release before the synchronised straps are valid
`define FET_STRAP_WAIT    2'h2

// MLT-3 phases: plus, zero, minus, zero
`define FET_MLT_PLUS      2'h0
`define FET_MLT_MINUS     2'h2

`endif

// ===== fet_pkg.sv
// Types shared by the fast Ethernet transmit code-group encoder
package fet_pkg;

    // Transmit sequencing states, one per code-group slot
    typedef enum logic [2:0] {
        FET_ST_IDLE,
        FET_ST_SSD_J,
        FET_ST_SSD_K,
        FET_ST_DATA,
        FET_ST_ESD_T,
        FET_ST_ESD_R
    } fet_state_t;

    // Nibble from the MAC transmit interface
    typedef struct packed {
        logic       en;
        logic       er;
        logic [3:0] data;
    } fet_mii_tx_t;

    // Line side: NRZI bit and the two alternately phased MLT-3 streams
    typedef struct packed {
        logic nrzi;
        logic mlt_pos;
        logic mlt_neg;
    } fet_line_t;

endpackage

// ===== fet_tx_pcs.sv
// Fast Ethernet transmit path: 4B/5B encoder, scrambler, NRZI and MLT-3
// Summary of operation
// - Each data nibble maps to its fixed 5-bit code-group from the sixteen-entry table.
// - A frame starts with J then K in place of the first eight preamble bits.
// - Remaining preamble and data nibbles are encoded as data code-groups.
// - When transmit enable drops, T then R close the frame.
// - After R, IDLE code-groups run continuously until transmit enable returns.
// - Code-group 00100 is the Halt symbol marking an error in the stream.
// - Control code-groups other than Halt, or unassigned ones, inside a data field are invalid and flagged.
// - An 11-bit closed-loop LFSR is XORed with the serial NRZ bits.
// - The scrambler seed comes from the five PHY address straps.
// - A bypass input sends the encoded stream out unscrambled.
// - NRZ to NRZI encoding is always applied and cannot be bypassed.
// - The NRZI stage also gives an MLT value for internal loopback.
// - MLT-3 splits NRZI into two streams with alternately phased one events.
// - Line output carries the plain NRZI bit alongside the two MLT-3 streams.
// - MII nibbles become a scrambled serial stream at the 125 Mb/s bit rate.
// - Sequencing follows the standard 100BASE-TX transmit state machine.
`timescale 1ns/1ps

`include "fet_cfg.svh"

module fet_tx_pcs (
    // Clock, reset and bit-slot enable
    input  wire logic              ref_clk,
    input  wire logic              reset_n,
    input  wire logic              clk_en,
    // MAC transmit nibble interface
    input  wire fet_pkg::fet_mii_tx_t mii_tx,
    output logic                   nibble_take,
    // Configuration pins
    input  wire logic [4:0]        phy_address_straps,
    input  wire logic              scr_bypass,
    // Line side and loopback
    output fet_pkg::fet_line_t     line_out,
    output logic [1:0]             loopback_mlt,
    output logic                   code_invalid
);

    // Strap synchronisation and seed capture
    logic [4:0]               strap_meta_reg;
    logic [4:0]               strap_sync_reg;
    logic [1:0]               init_cnt_reg;
    logic [1:0]               init_cnt_next;
    logic                     seed_done_reg;
    logic                     seed_load;
    logic                     seed_fire;
    logic [`FET_LFSR_W-1:0]   seed_value;

    // Straps are asynchronous pins: two flops before anything reads them
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            strap_meta_reg <= 5'h00;
            strap_sync_reg <= 5'h00;
        end else begin
            strap_meta_reg <= phy_address_straps;
            strap_sync_reg <= strap_meta_reg;
        end
    end

    // Seed is loaded once, after the synchroniser has filled; no clock enable
    // here so the seed is ready before the first bit slot
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            init_cnt_reg  <= 2'h0;
            seed_done_reg <= 1'b0;
        end else if (!seed_done_reg) begin
            init_cnt_reg  <= init_cnt_next;
            seed_done_reg <= seed_load;
        end
    end

    // Fill bits keep the seed nonzero even with all straps low
    assign seed_load     = (init_cnt_reg == `FET_STRAP_WAIT);
    assign seed_fire     = seed_load && !seed_done_reg;
    assign init_cnt_next = init_cnt_reg + 2'h1;
    assign seed_value    = {strap_sync_reg, `FET_SEED_FILL};

    // Code-group slot timing
    logic [2:0]               bit_cnt_reg;
    logic [2:0]               bit_cnt_next;
    logic                     group_end;
    logic                     run;

    // Nothing moves until the seed is in place and the slot enable is high
    assign run       = clk_en && seed_done_reg;
    assign group_end = run && (bit_cnt_reg == `FET_CG_LAST);

    // Counter wraps after the fifth slot of a group
    assign bit_cnt_next = group_end ? 3'h0 : bit_cnt_reg + 3'h1;

    // Five bit slots per code-group
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            bit_cnt_reg <= 3'h0;
        end else if (run) begin
            bit_cnt_reg <= bit_cnt_next;
        end
    end

    // 4B/5B data mapping
    function automatic logic [4:0] fet_map4b5b(input logic [3:0] nib);
        logic [4:0] cg;
        cg = `FET_CG_IDLE;
        unique case (nib)
            4'h0: cg = 5'h1e;
            4'h1: cg = 5'h09;
            4'h2: cg = 5'h14;
            4'h3: cg = 5'h15;
            4'h4: cg = 5'h0a;
            4'h5: cg = 5'h0b;
            4'h6: cg = 5'h0e;
            4'h7: cg = 5'h0f;
            4'h8: cg = 5'h12;
            4'h9: cg = 5'h13;
            4'ha: cg = 5'h16;
            4'hb: cg = 5'h17;
            4'hc: cg = 5'h1a;
            4'hd: cg = 5'h1b;
            4'he: cg = 5'h1c;
            4'hf: cg = 5'h1d;
        endcase
        return cg;
    endfunction

    // True for any of the sixteen data code-groups
    function automatic logic fet_is_data(input logic [4:0] cg);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < 16; i++) begin
            if (fet_map4b5b(4'(i)) == cg) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    // Transmit sequencing
    fet_pkg::fet_state_t      state_reg;
    fet_pkg::fet_state_t      state_next;
    logic [4:0]               group_next;
    logic                     take_next;
    logic [4:0]               data_group;

    // Halt replaces the data group while the MAC flags an error
    assign data_group = mii_tx.er ? `FET_CG_HALT : fet_map4b5b(mii_tx.data);

    // Next slot choice: state, code-group and whether a nibble is consumed.
    // J swallows one preamble nibble and K another only while enable is still high, so at most two nibbles go in total.
    always_comb begin
        state_next = state_reg;
        group_next = `FET_CG_IDLE;
        take_next  = 1'b0;
        unique case (state_reg)
            fet_pkg::FET_ST_IDLE, fet_pkg::FET_ST_ESD_R: begin
                if (mii_tx.en) begin
                    state_next = fet_pkg::FET_ST_SSD_J;
                    group_next = `FET_CG_J;
                    take_next  = 1'b1;
                end else begin
                    state_next = fet_pkg::FET_ST_IDLE;
                    group_next = `FET_CG_IDLE;
                end
            end
            fet_pkg::FET_ST_SSD_J: begin
                // Enable dropping inside the delimiter still gets K, then T/R
                state_next = fet_pkg::FET_ST_SSD_K;
                group_next = `FET_CG_K;
                take_next  = mii_tx.en;
            end
            fet_pkg::FET_ST_SSD_K, fet_pkg::FET_ST_DATA: begin
                if (mii_tx.en) begin
                    state_next = fet_pkg::FET_ST_DATA;
                    group_next = data_group;
                    take_next  = 1'b1;
                end else begin
                    state_next = fet_pkg::FET_ST_ESD_T;
                    group_next = `FET_CG_T;
                end
            end
            fet_pkg::FET_ST_ESD_T: begin
                state_next = fet_pkg::FET_ST_ESD_R;
                group_next = `FET_CG_R;
            end
            default: begin
                // Unused state codes fall back to idle rather than lock up
                state_next = fet_pkg::FET_ST_IDLE;
            end
        endcase
    end

    // Nibble taken on the last bit slot of the previous group
    assign nibble_take = group_end && take_next;

    // Serialiser: leftmost code-group bit leaves first
    logic [4:0]               shift_reg;
    logic [4:0]               shift_next;
    logic [4:0]               cur_group_reg;
    logic                     in_data_reg;
    logic                     in_data_next;
    logic                     invalid_next;
    logic                     nrz_bit;

    // Next shifter content: a fresh group at the slot end, else one bit along
    assign shift_next   = group_end ? group_next : {shift_reg[3:0], 1'b0};
    assign in_data_next = (state_next == fet_pkg::FET_ST_DATA);

    // Sequencer state, with a copy of the group now on the line for the check
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg     <= fet_pkg::FET_ST_IDLE;
            cur_group_reg <= `FET_CG_IDLE;
            in_data_reg   <= 1'b0;
        end else if (group_end) begin
            state_reg     <= state_next;
            cur_group_reg <= group_next;
            in_data_reg   <= in_data_next;
        end
    end

    // Shifter moves once per bit slot
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            shift_reg <= `FET_CG_IDLE;
        end else if (run) begin
            shift_reg <= shift_next;
        end
    end

    assign nrz_bit = shift_reg[4];

    // A Halt in a data slot is legal; any other non-data group there is not.
    // The group copy is judged because the shifter holds only its last bit by the slot end.
    assign invalid_next = group_end && in_data_reg &&
                          !fet_is_data(cur_group_reg) &&
                          (cur_group_reg != `FET_CG_HALT);

    // Pulse lasts one slot and freezes with everything else while the enable is low
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            code_invalid <= 1'b0;
        end else if (run) begin
            code_invalid <= invalid_next;
        end
    end

    // Scrambler
    logic [`FET_LFSR_W-1:0]   lfsr_reg;
    logic [`FET_LFSR_W-1:0]   lfsr_next;
    logic                     lfsr_fb;
    logic                     scr_bit;

    // Closed loop: the LFSR runs on its own output, independent of data
    assign lfsr_fb = lfsr_reg[`FET_LFSR_TAP_HI] ^ lfsr_reg[`FET_LFSR_TAP_LO];
    assign scr_bit = scr_bypass ? nrz_bit : (nrz_bit ^ lfsr_fb);

    // Shift left with the feedback entering at bit 0
    assign lfsr_next = {lfsr_reg[`FET_LFSR_W-2:0], lfsr_fb};

    // Seed loads once; afterwards the register steps with the bit slots

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            lfsr_reg <= '0;
        end else if (seed_fire) begin
            lfsr_reg <= seed_value;
        end else if (run) begin
            lfsr_reg <= lfsr_next;
        end
    end

    // NRZI and MLT-3
    logic                     nrzi_reg;
    logic [1:0]               mlt_phase_reg;
    logic [1:0]               mlt_phase_next;
    logic                     mlt_pos_reg;
    logic                     mlt_neg_reg;
    logic                     nrzi_toggle;

    // No bypass exists for this stage on purpose
    assign nrzi_toggle    = run && scr_bit;
    assign mlt_phase_next = mlt_phase_reg + 2'h1;

    // Every NRZI transition advances the MLT-3 phase by one step
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            nrzi_reg      <= 1'b0;
            mlt_phase_reg <= `FET_MLT_PLUS;
            mlt_pos_reg   <= 1'b1;
            mlt_neg_reg   <= 1'b0;
        end else if (nrzi_toggle) begin
            nrzi_reg      <= ~nrzi_reg;
            mlt_phase_reg <= mlt_phase_next;
            mlt_pos_reg   <= (mlt_phase_next == `FET_MLT_PLUS);
            mlt_neg_reg   <= (mlt_phase_next == `FET_MLT_MINUS);
        end
    end

    // Registered streams keep decode glitches off the line driver inputs
    assign line_out.nrzi    = nrzi_reg;
    assign line_out.mlt_pos = mlt_pos_reg;
    assign line_out.mlt_neg = mlt_neg_reg;

    // Loopback gets the encoded level: bit1 minus, bit0 plus, 00 is zero
    assign loopback_mlt = {line_out.mlt_neg, line_out.mlt_pos};

endmodule

// ===== fet_tx_pcs_asserts.sv
// Port assertions for the transmit encoder
`timescale 1ns/1ps
module fet_tx_pcs_chk (
    // Clock and reset
    input wire logic               ref_clk,
    input wire logic               reset_n,
    // Watched ports
    input wire logic               clk_en,
    input wire logic               nibble_take,
    input wire logic               code_invalid,
    input wire fet_pkg::fet_line_t line_out,
    input wire logic [1:0]         loopback_mlt
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);
    logic       was_pos_reg;
    logic [1:0] ph;
    logic       nz;
    // Phase pair and NRZI bit
    assign ph = {line_out.mlt_neg, line_out.mlt_pos};
    assign nz = line_out.nrzi;
    // Last nonzero phase, so a repeated polarity can be caught
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n)
            was_pos_reg <= 1'b1;
        else if (ph != 2'h0)
            was_pos_reg <= ph[0];
    end
    a_reset_state: assert property ($rose(reset_n) |-> ph == 2'h1 && !nz)
        else $error("bad line after reset");
    a_mlt_exclusive: assert property (ph != 2'h3)
        else $error("both MLT streams high");
    a_loopback_copy: assert property (loopback_mlt == ph)
        else $error("loopback differs");
    a_mlt_hold: assert property (!$changed(nz) |-> $stable(ph))
        else $error("MLT moved without NRZI edge");
    a_mlt_step: assert property ($changed(nz) |-> (ph == 2'h0) != ($past(ph) == 2'h0))
        else $error("MLT missed zero step");
    a_mlt_alternate: assert property ($rose(ph != 2'h0) |-> ph[1] == was_pos_reg)
        else $error("MLT polarity repeated");
    a_nrzi_frozen: assert property (!clk_en |=> $stable(nz))
        else $error("NRZI moved outside a slot");
    a_take_spacing: assert property (nibble_take |-> clk_en ##1 !nibble_take [*4])
        else $error("nibble taken too soon");
    a_code_valid: assert property (!code_invalid)
        else $error("invalid group flagged");
endmodule
bind fet_tx_pcs fet_tx_pcs_chk u_chk (
    .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en),
    .nibble_take(nibble_take), .code_invalid(code_invalid),
    .line_out(line_out), .loopback_mlt(loopback_mlt)
);

// ===== fet_mac_model.sv
// Behavioural MAC feeding the transmit nibble interface
`timescale 1ns/1ps
module fet_mac_model (
    // Clock and reset
    input  wire logic            ref_clk,
    input  wire logic            reset_n,
    // Handshake from the encoder
    input  wire logic            clk_en,
    input  wire logic            nibble_take,
    // Nibble towards the encoder
    output fet_pkg::fet_mii_tx_t mii_tx
);
    logic [4:0] nib_q[$];
    logic       took;
    initial mii_tx = '0;
    // A nibble counts as taken only on a bit-slot edge
    always @(posedge ref_clk)
        took <= nibble_take && clk_en && mii_tx.en;
    // Next nibble after the falling edge, held until taken; idle data wanders
    always @(negedge ref_clk) begin
        if (!reset_n)
            nib_q.delete();
        else if (took)
            void'(nib_q.pop_front());
        mii_tx <= nib_q.size() != 0 ? {1'b1, nib_q[0]} : {2'b00, 4'($urandom)};
    end
endmodule

// ===== tb.sv
// Bench: random frames in, line stream decoded and compared
`timescale 1ns/1ps
module tb;
    logic                 ref_clk, reset_n, clk_en, scr_bypass, dense;
    logic                 nibble_take, code_invalid, prev_nrzi, in_frame;
    logic [4:0]           phy_address_straps, want;
    logic [1:0]           loopback_mlt;
    logic [14:0]          sr;
    logic [10:0]          lf;
    logic [4:0]           exp_q[$];
    fet_pkg::fet_mii_tx_t mii_tx;
    fet_pkg::fet_line_t   line_out;
    int                   fail_count = 0, comparisons = 0, sent = 0, seen = 0;
    int                   nb, cnt, n, i;

    fet_tx_pcs dut (.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en),
        .mii_tx(mii_tx), .nibble_take(nibble_take), .scr_bypass(scr_bypass),
        .phy_address_straps(phy_address_straps), .line_out(line_out),
        .loopback_mlt(loopback_mlt), .code_invalid(code_invalid));
    fet_mac_model mac (.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en),
        .nibble_take(nibble_take), .mii_tx(mii_tx));

    // Nibble to data code-group
    function automatic logic [4:0] enc(input logic [3:0] d);
        logic [4:0] t[16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
            5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
        return t[d];
    endfunction

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic finish_test;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // Per slot the NRZI edge gives the bit and a model LFSR removes the key;
    // slots open only well after release so the seed is surely loaded
    always @(negedge ref_clk) begin
        if (!reset_n) begin
            cnt = 0;
            lf = {phy_address_straps, 6'h3f};
            in_frame = 1'b0;
            sr = '0;
        end else begin
            if (cnt < 8)
                cnt++;
            if (clk_en) begin
                sr = {sr[13:0], line_out.nrzi ^ prev_nrzi ^ (scr_bypass ? 1'b0 : lf[10] ^ lf[8])};
                lf = {lf[9:0], lf[10] ^ lf[8]};
                check(16'(code_invalid), 16'h0000, "invalid");
                nb++;
                if (!in_frame && sr[9:0] == 10'h311 && sr[14:10] inside {5'h1f, 5'h07}) begin
                    in_frame = 1'b1;
                    nb = 0;
                    seen++;
                end else if (in_frame && nb == 5) begin
                    want = exp_q.size() != 0 ? exp_q.pop_front() : 5'h1f;
                    check(16'(sr[4:0]), 16'(want), "group");
                    nb = 0;
                    in_frame = want != 5'h07;
                end
            end
        end
        prev_nrzi = line_out.nrzi;
        clk_en <= cnt > 5 && (dense || $urandom % 8 < 5);
    end

    // One frame: preamble nibbles that become J K, data, then T R;
    // k 0 sweeps every nibble, k 1 drops enable inside the delimiter, right after J
    task automatic send(input int k);
        logic [4:0] v;
        int len;
        len = k == 0 ? 16 : k == 1 ? -1 : int'(1 + $urandom % 12);
        #1;
        for (i = -2; i < len; i++) begin
            v = {k > 0 && i >= 0 && $urandom % 8 == 0, k == 0 ? 4'(i) : 4'($urandom)};
            mac.nib_q.push_back(v);
            if (i >= 0)
                exp_q.push_back(v[4] ? 5'h04 : enc(v[3:0]));
        end
        exp_q.push_back(5'h0d);
        exp_q.push_back(5'h07);
        sent++;
    endtask

    // Reset with fresh straps, then eight frames each after a random gap of 0 to 29 cycles
    task automatic phase(input logic byp);
        @(negedge ref_clk);
        reset_n <= 1'b0;
        scr_bypass <= byp;
        dense <= byp;
        phy_address_straps <= 5'($urandom);
        repeat (10) @(negedge ref_clk);
        reset_n <= 1'b1;
        for (n = 0; n < 8; n++) begin
            repeat ($urandom % 30) @(negedge ref_clk);
            send(n + byp);
            for (i = 0; i < 3000 && exp_q.size() != 0; i++)
                @(negedge ref_clk);
            check(16'(seen), 16'(sent), "frames");
        end
    endtask

    initial begin
        n = $urandom(32'hc3c10df6);
        {reset_n, clk_en, scr_bypass, dense} = 4'h0;
        phy_address_straps = 5'h00;
        phase(1'b0);
        phase(1'b1);
        finish_test;
    end

    // Watchdog far beyond the expected run
    initial begin
        #200us;
        fail_count++;
        finish_test;
    end
endmodule
